//--- inc/adcsel_pkg.sv
// package: register map, field layout and types of the step input select block
package adcsel_pkg;

  // register map
  localparam logic [7:0] ADCSEL_OFS_SEL = 8'h40;
  localparam logic [7:0] ADCSEL_OFS_STEP = 8'h48;
  localparam logic [31:0] ADCSEL_RST_SEL = 32'h0000_0000;
  localparam logic [31:0] ADCSEL_RD_UNMAPPED = 32'h0000_0000;

  // field layout: step n select sits at bits 4n-3:4n-4
  localparam int ADCSEL_NSTEP = 8;
  localparam int ADCSEL_FLD_W = 2;
  localparam int ADCSEL_FLD_PITCH = 4;
  localparam int ADCSEL_STEP1_LSB = 0;
  localparam int ADCSEL_STEP2_LSB = 4;
  localparam int ADCSEL_STEP3_LSB = 8;
  localparam int ADCSEL_STEP4_LSB = 12;
  localparam int ADCSEL_STEP5_LSB = 16;
  localparam int ADCSEL_STEP6_LSB = 20;
  localparam int ADCSEL_STEP7_LSB = 24;
  localparam int ADCSEL_STEP8_LSB = 28;
  // writable bits of the select register; reserved pairs are zero here
  localparam logic [31:0] ADCSEL_WR_MASK = 32'h3333_3333;

  // wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } adcsel_wb_req_t;

  // wishbone answer
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } adcsel_wb_rsp_t;

  // one analog input channel index per step
  typedef logic [ADCSEL_FLD_W-1:0] adcsel_chan_t;

endpackage

//--- src/adcsel_decode.sv
// module: one-hot decode of a step select value into an analog input enable
`timescale 1ns/10ps
module adcsel_decode
  import adcsel_pkg::*;
(
  input wire adcsel_pkg::adcsel_chan_t sel_i,
  output logic [3:0] onehot_o
);

  // value n routes analog input n straight to the converter
  always_comb
  begin
    onehot_o = 4'h0;
    onehot_o[sel_i] = 1'b1;
  end

endmodule

//--- src/adcsel_top.sv
// module: sequencer 0 step input select register with wishbone slave
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
// Function
// - step eight input from bits 29:28
// - step seven input from bits 25:24
// - step five input from bits 17:16
// - step four input from bits 13:12
// - step three input from bits 9:8
// - step two input from bits 5:4
// - step one input from bits 1:0
// - select value is the analog channel index
module adcsel_top
  import adcsel_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire adcsel_pkg::adcsel_wb_req_t wb_req_i,
  output adcsel_pkg::adcsel_wb_rsp_t wb_rsp_o,
  input wire logic [2:0] cur_step_i,
  output adcsel_pkg::adcsel_chan_t cur_chan_o,
  output logic [3:0] cur_input_en_o,
  output logic [31:0] sel_word_o
);
  import adcsel_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  // select word, bus answer and the channel chosen for the current step;
  // the channel lags cur_step_i by one edge, so the sequencer must show
  // the next step one cycle before it samples the channel
  typedef struct packed {
    logic [31:0] sel;
    logic ack;
    logic [31:0] rdat;
    adcsel_chan_t chan;
  } adcsel_state_t;

  adcsel_state_t state_ff;
  adcsel_state_t nxt_state;
  adcsel_chan_t step_fld [ADCSEL_NSTEP];
  logic [31:0] bytemask;
  logic [31:0] rd_mux;
  logic access;
  logic wr_sel;

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  // fixed slices; the reserved pairs between them are never read
  assign step_fld[0] = state_ff.sel[ADCSEL_STEP1_LSB +: ADCSEL_FLD_W];
  assign step_fld[1] = state_ff.sel[ADCSEL_STEP2_LSB +: ADCSEL_FLD_W];
  assign step_fld[2] = state_ff.sel[ADCSEL_STEP3_LSB +: ADCSEL_FLD_W];
  assign step_fld[3] = state_ff.sel[ADCSEL_STEP4_LSB +: ADCSEL_FLD_W];
  assign step_fld[4] = state_ff.sel[ADCSEL_STEP5_LSB +: ADCSEL_FLD_W];
  assign step_fld[5] = state_ff.sel[ADCSEL_STEP6_LSB +: ADCSEL_FLD_W];
  assign step_fld[6] = state_ff.sel[ADCSEL_STEP7_LSB +: ADCSEL_FLD_W];
  assign step_fld[7] = state_ff.sel[ADCSEL_STEP8_LSB +: ADCSEL_FLD_W];

  // ----------------------------------------
  // byte lane mask
  // ----------------------------------------
  // byte enables widen to a bit mask; lane checks sit beside it
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign bytemask[gi*8 +: 8] = {8{wb_req_i.sel[gi]}};
      // a selected lane loads, its reserved pairs forced to zero
      AST_LANE_LOAD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_sel && wb_req_i.sel[gi]
        |=> sel_word_o[gi*8 +: 8]
          == ($past(wb_req_i.dat[gi*8 +: 8]) & ADCSEL_WR_MASK[gi*8 +: 8]))
        else $error("selected byte lane not loaded");
      // an unselected lane keeps its old value
      AST_LANE_KEEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_sel && !wb_req_i.sel[gi]
        |=> sel_word_o[gi*8 +: 8] == $past(sel_word_o[gi*8 +: 8]))
        else $error("unselected byte lane changed");
    end
  endgenerate

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // a request is taken only while no answer stands, one answer per request
  assign access = wb_req_i.cyc & wb_req_i.stb & ~state_ff.ack;
  // write strobe for the select word; other offsets ignore writes
  assign wr_sel = access & wb_req_i.we & (wb_req_i.adr == ADCSEL_OFS_SEL);

  // decoded from the live address; the answer is registered below
  // read mux, unmapped addresses read zero
  always_comb
  begin
    unique case (wb_req_i.adr)
      ADCSEL_OFS_SEL: rd_mux = state_ff.sel & ADCSEL_WR_MASK;
      ADCSEL_OFS_STEP: rd_mux = {29'h0000_0000, cur_step_i};
      default: rd_mux = ADCSEL_RD_UNMAPPED;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.ack = access;
    nxt_state.rdat = access ? rd_mux : state_ff.rdat;
    // writes keep reserved pairs at zero; unselected lanes hold
    if (wr_sel)
    begin
      nxt_state.sel = ((state_ff.sel & ~bytemask) | (wb_req_i.dat & bytemask))
        & ADCSEL_WR_MASK;
    end
    // pick the field of the step the sequencer shows now
    nxt_state.chan = step_fld[cur_step_i];
  end

  // synchronous reset; the reset branch loads constants only
  // registered state
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_ff.sel <= ADCSEL_RST_SEL;
      state_ff.ack <= 1'b0;
      state_ff.rdat <= 32'h0000_0000;
      state_ff.chan <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // answer and read data come straight from flip-flops
  assign wb_rsp_o.ack = state_ff.ack;
  assign wb_rsp_o.dat = state_ff.rdat;
  assign cur_chan_o = state_ff.chan;
  assign sel_word_o = state_ff.sel;

  // channel enable for the analog switch
  adcsel_decode u_decode
  (
    .sel_i(state_ff.chan),
    .onehot_o(cur_input_en_o)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // step checks look one edge back because the channel is registered;
  // they stay quiet while reset is applied
  AST_STEP8: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h7 |=> cur_chan_o == $past(sel_word_o[29:28]))
    else $error("step eight channel wrong");
  AST_STEP7: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h6 |=> cur_chan_o == $past(sel_word_o[25:24]))
    else $error("step seven channel wrong");
  AST_STEP6: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h5 |=> cur_chan_o == $past(sel_word_o[21:20]))
    else $error("step six channel wrong");
  AST_STEP5: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h4 |=> cur_chan_o == $past(sel_word_o[17:16]))
    else $error("step five channel wrong");
  AST_STEP4: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h3 |=> cur_chan_o == $past(sel_word_o[13:12]))
    else $error("step four channel wrong");
  AST_STEP3: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h2 |=> cur_chan_o == $past(sel_word_o[9:8]))
    else $error("step three channel wrong");
  AST_STEP2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h1 |=> cur_chan_o == $past(sel_word_o[5:4]))
    else $error("step two channel wrong");
  AST_STEP1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_step_i == 3'h0 |=> cur_chan_o == $past(sel_word_o[1:0]))
    else $error("step one channel wrong");
  AST_ONEHOT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_input_en_o == (4'h1 << cur_chan_o))
    else $error("input enable does not match channel");
  AST_RSVD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (sel_word_o & ~ADCSEL_WR_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  AST_WRITE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (access && wb_req_i.we && wb_req_i.adr == ADCSEL_OFS_SEL && wb_req_i.sel == 4'hF)
    |=> sel_word_o == ($past(wb_req_i.dat) & ADCSEL_WR_MASK))
    else $error("full write not stored");
  AST_ACK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held two cycles");

  // ----------------------------------------
  // reset assertions
  // ----------------------------------------
  // reset clears the whole select word in one edge
  AST_RST_SEL: assert property (@(posedge ref_clk_i)
    rst_i |=> sel_word_o == ADCSEL_RST_SEL)
    else $error("select word not cleared by reset");
  // no answer is left standing across a reset
  AST_RST_ACK: assert property (@(posedge ref_clk_i)
    rst_i |=> !wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000)
    else $error("bus answer not cleared by reset");
  // the analog switch falls back to input zero
  AST_RST_CHAN: assert property (@(posedge ref_clk_i)
    rst_i |=> cur_chan_o == 2'h0 && cur_input_en_o == 4'h1)
    else $error("channel not cleared by reset");

  // ----------------------------------------
  // bus handshake assertions
  // ----------------------------------------
  // a fresh request is answered on the next edge
  AST_ACK_TAKEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not answered");
  // no answer without a request
  AST_ACK_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(wb_req_i.cyc && wb_req_i.stb) |=> !wb_rsp_o.ack)
    else $error("answer without request");
  // a standing read value is kept until the next request
  AST_RDAT_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !access |=> $stable(wb_rsp_o.dat))
    else $error("read data moved without a request");

  // ----------------------------------------
  // read data assertions
  // ----------------------------------------
  // the select word reads back as stored
  AST_RD_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    access && !wb_req_i.we && wb_req_i.adr == ADCSEL_OFS_SEL
    |=> wb_rsp_o.dat == ($past(sel_word_o) & ADCSEL_WR_MASK))
    else $error("select word read back wrong");
  // reserved pairs always read zero
  AST_RD_RSVD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    access && !wb_req_i.we && wb_req_i.adr == ADCSEL_OFS_SEL
    |=> (wb_rsp_o.dat & ~ADCSEL_WR_MASK) == 32'h0000_0000)
    else $error("reserved pair read back set");
  // the step register shows the step seen at the request
  AST_RD_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    access && !wb_req_i.we && wb_req_i.adr == ADCSEL_OFS_STEP
    |=> wb_rsp_o.dat == 32'($past(cur_step_i)))
    else $error("step register read back wrong");
  // any other address reads the unmapped value
  AST_RD_UNMAPPED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    access && !wb_req_i.we && wb_req_i.adr != ADCSEL_OFS_SEL
    && wb_req_i.adr != ADCSEL_OFS_STEP |=> wb_rsp_o.dat == ADCSEL_RD_UNMAPPED)
    else $error("unmapped read not zero");
  // a write answers with the word as it stood before the write
  AST_WR_ANSWER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_sel |=> wb_rsp_o.dat == ($past(sel_word_o) & ADCSEL_WR_MASK))
    else $error("write answer data wrong");

  // ----------------------------------------
  // write protection assertions
  // ----------------------------------------
  // only a write to the select offset may change the word
  AST_WR_OTHER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !wr_sel |=> $stable(sel_word_o))
    else $error("select word changed without a write");

  // ----------------------------------------
  // channel and enable assertions
  // ----------------------------------------
  // a field value of one drives analog input one
  AST_CHAN_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur_chan_o == 2'h1 |-> cur_input_en_o == 4'h2)
    else $error("value one does not select input one");

  // every step lands on its field at the regular pitch
  generate
    for (gi = 0; gi < ADCSEL_NSTEP; gi++)
    begin : g_step_chk
      AST_STEP_PITCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cur_step_i == 3'(gi)
        |=> cur_chan_o == $past(sel_word_o[gi*ADCSEL_FLD_PITCH +: ADCSEL_FLD_W]))
        else $error("step channel off the field pitch");
    end
  endgenerate

  // each channel value lights exactly its own enable bit
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_en_chk
      AST_EN_BIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cur_input_en_o[gi] == (cur_chan_o == 2'(gi)))
        else $error("enable bit does not match channel");
    end
  endgenerate

  // the enable only moves with the channel
  AST_EN_STEADY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $stable(cur_chan_o) |-> $stable(cur_input_en_o))
    else $error("enable moved without the channel");
  // a steady step and word keep the channel steady
  AST_CHAN_STEADY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $stable(cur_step_i) && $stable(sel_word_o) |=> $stable(cur_chan_o))
    else $error("channel moved on its own");

endmodule

//--- bench/tb_top.sv
// testbench: step input select register over wishbone and step outputs
`timescale 1ns/10ps
module tb_top;
  import adcsel_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  adcsel_wb_req_t req = '0;
  adcsel_wb_rsp_t wb_rsp_o;
  logic [2:0] cur_step_i = 3'h0;
  adcsel_chan_t cur_chan_o;
  logic [3:0] cur_input_en_o;
  logic [31:0] sel_word_o;
  logic [31:0] mdl = 32'h0;
  logic [31:0] v;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int tests_run = 0;
  // ----------------------------------------
  // clock, design, checking tasks
  // ----------------------------------------
  always #25 ref_clk_i = ~ref_clk_i;
  adcsel_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(wb_rsp_o),
    .cur_step_i(cur_step_i), .cur_chan_o(cur_chan_o), .cur_input_en_o(cur_input_en_o),
    .sel_word_o(sel_word_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    input logic [3:0] sel);
    if (!we)
      exp_q.push_back(adr == ADCSEL_OFS_SEL ? mdl
        : adr == ADCSEL_OFS_STEP ? 32'(cur_step_i) : ADCSEL_RD_UNMAPPED);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    // only the watchdog ends a wait that never sees ack
    do
      @(posedge ref_clk_i);
    while (wb_rsp_o.ack !== 1'b1);
    if (we && adr == ADCSEL_OFS_SEL)
      for (int b = 0; b < 4; b++)
        if (sel[b])
          mdl[b*8+:8] = dat[b*8+:8] & ADCSEL_WR_MASK[b*8+:8];
    req <= '0;
    @(posedge ref_clk_i);
  endtask
  // every step: channel index and one-hot enable
  task automatic steps();
    for (int k = 0; k < 8; k++)
    begin
      cur_step_i <= 3'(k);
      @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      check(32'(cur_chan_o), 32'(mdl[k*4+:2]));
      check(32'(cur_input_en_o), 32'h1 << mdl[k*4+:2]);
    end
    check(sel_word_o, mdl);
  endtask
  // ----------------------------------------
  // read data monitor and watchdog
  // ----------------------------------------
  always @(posedge ref_clk_i)
    if (wb_rsp_o.ack === 1'b1 && req.we === 1'b0)
      check(wb_rsp_o.dat, exp_q.pop_front());
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    miscompares++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    v = $urandom(8);
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADCSEL_OFS_SEL, 32'h0, 4'hF);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, ADCSEL_OFS_SEL, $urandom, 4'hF);
      wb(1'b0, ADCSEL_OFS_SEL, 32'h0, 4'hF);
      steps();
    end
    wb(1'b1, ADCSEL_OFS_SEL, 32'hFFFF_FFFF, 4'hF);
    v = (mdl & ~32'h0000_0030) | 32'h0000_0010;
    wb(1'b1, ADCSEL_OFS_SEL, v ^ 32'hFFFF_FF00, 4'h1);
    wb(1'b0, ADCSEL_OFS_SEL, 32'h0, 4'hF);
    steps();
    wb(1'b1, 8'h44, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 8'h44, 32'h0, 4'hF);
    wb(1'b0, ADCSEL_OFS_STEP, 32'h0, 4'hF);
    wb(1'b0, ADCSEL_OFS_SEL, 32'h0, 4'hF);
    rst_i <= 1'b1;
    mdl = ADCSEL_RST_SEL;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADCSEL_OFS_SEL, 32'h0, 4'hF);
    steps();
    tally_and_finish();
  end
endmodule
